// *** design/tsa_pkg.sv ***
// Shared constants and types for the time slot assigner port
package tsa_pkg;
    // Serial word length in port clock falling edges
    localparam int WORD_BITS = 8;
    // Width of the binary slot number
    localparam int SLOT_BITS = 6;
    // Width of the hardwired identity
    localparam int ID_BITS = 5;
    // Width of the status field
    localparam int STAT_BITS = 3;
    // Bit clocks per time slot
    localparam int BITS_PER_SLOT = 8;
    // Low bits of the bit counter that index inside a slot
    localparam int SLOT_SHIFT = 3;
    // Bit counter width, 64 slots of 8 bits
    localparam int CNT_BITS = 9;
    // Width of the shift counter
    localparam int SH_CNT_BITS = 4;
    // Shift count that completes a word
    localparam logic [3:0] SH_FULL = 4'h8;
    // Bit clock edges from frame start to acknowledge pull
    localparam logic [1:0] ACK_DELAY = 2'h3;
    // Field positions in the slot and mode word
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int SLOT_MSB = 5;
    // Field positions in the address and control word
    localparam int STAT_MSB = 7;
    localparam int STAT_LSB = 5;
    localparam int ID_MSB = 4;
    // Position of each status output inside the status field
    localparam int STAT_Q0 = 0;
    localparam int STAT_Q1 = 1;
    localparam int STAT_Q2 = 2;
    // Mode codes, first received bit is the upper one
    localparam logic [1:0] MODE_BOTH = 2'h0;
    localparam logic [1:0] MODE_TX = 2'h1;
    localparam logic [1:0] MODE_RX = 2'h2;
    localparam logic [1:0] MODE_IDLE = 2'h3;
    // Values after reset
    localparam logic [5:0] RST_SLOT = 6'h00;
    localparam logic [2:0] RST_STATUS = 3'h0;
    localparam logic [7:0] RST_WORD = 8'h00;
    localparam logic [8:0] RST_CNT = 9'h000;
    // Serial port sequencer states
    typedef enum logic [1:0] {
        TSA_IDLE,
        TSA_SHIFT,
        TSA_DONE
    } tsa_port_state_t;
endpackage

// *** design/tsa_sync.sv ***
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module tsa_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage, read only by the second stage
    logic [W-1:0] meta_q;

    // Two stages per bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // tsa_sync

// *** design/tsa_slot_timer.sv ***
// Per-direction bit counter and slot enable strobe
`timescale 1ns/100ps
module tsa_slot_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic bck_rise,
    input wire logic fs,
    input wire logic [5:0] slot,
    input wire logic en,
    output logic frame_start,
    output logic enable_q
);
    // Frame sync seen at the previous bit clock rise
    logic fs_prev_q;
    // Bit position inside the frame
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    // Set once the first frame start has been seen
    logic locked_q;
    // Slot that the next bit falls in
    logic [5:0] slot_of_next;
    logic hit;

    assign frame_start = bck_rise & fs & ~fs_prev_q;
    assign cnt_d = frame_start ? tsa_pkg::RST_CNT : cnt_q + 9'h001;
    // divide by eight for slot rate
    assign slot_of_next = cnt_d[8:tsa_pkg::SLOT_SHIFT];
    assign hit = (slot_of_next == slot);

    // Counter advances on each bit clock rise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fs_prev_q <= 1'b0;
            cnt_q <= tsa_pkg::RST_CNT;
            locked_q <= 1'b0;
        end else if (bck_rise) begin
            fs_prev_q <= fs;
            cnt_q <= cnt_d;
            locked_q <= locked_q | frame_start;
        end
    end

    // strobe high for eight bit clocks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= 1'b0;
        end else if (bck_rise) begin
            enable_q <= en & hit & (locked_q | frame_start);
        end
    end

    property p_restart;
        @(posedge clk) disable iff (!resetn)
        frame_start |=> (cnt_q == tsa_pkg::RST_CNT);
    endproperty
    a_restart: assert property (p_restart)
        else $error("bit counter not restarted");

    // strobe rises only on a slot boundary
    property p_slot_edge;
        @(posedge clk) disable iff (!resetn)
        $rose(enable_q) |-> (cnt_q[2:0] == 3'h0);
    endproperty
    a_slot_edge: assert property (p_slot_edge)
        else $error("slot enable rose mid slot");
endmodule // tsa_slot_timer

// *** design/tsa_top.sv ***
// Time slot assigner: serial port, status outputs and slot strobes
`timescale 1ns/100ps
// What this block does
// - Sample serial lines on port clock fall
// - Port pins crossed safely into clk
// - Shift eight bits of slot word
// - Two mode bits, six slot bits
// - Shift address word alongside slot word
// - First three address bits set status
// - Accept only on exact identity match
// - One device per bank accepts
// - Select enables bank or single device
// - Clear input forces third status low
// - Acknowledge low three clocks after sync
// - Only accepting device pulls acknowledge
// - Acknowledge is pull-low only
// - Separate transmit and receive enables
// - Bit clock divided by eight
// - Sync leading edge marks slot zero
// - Enable high eight bit clocks
// - Mode codes both, tx, rx, idle
module tsa_top #(
    parameter bit ADDRESSED = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic port_clk,
    input wire logic chip_sel,
    input wire logic slot_mode_serial_in,
    input wire logic addr_ctl_in,
    input wire logic [4:0] hardwired_id_pins,
    input wire logic bit_clock_a,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    input wire logic status2_clear,
    output logic status_out0,
    output logic status_out1,
    output logic status_out2,
    output logic tx_slot_enable,
    output logic rx_slot_enable,
    output logic ack_out,
    output logic ack_oe
);
    // Synchronised pin levels
    logic [12:0] pins_raw;
    logic [12:0] pins_s;
    logic pclk_s;
    logic cs_s;
    logic di_s;
    logic ad_s;
    logic bck_s;
    logic fst_s;
    logic fsr_s;
    logic clr_s;
    logic [4:0] id_s;
    // Edge history of the port and bit clocks
    logic pclk_prev_q;
    logic bck_prev_q;
    logic pclk_fall;
    logic bck_rise;
    // Port sequencer
    tsa_pkg::tsa_port_state_t st_q;
    tsa_pkg::tsa_port_state_t st_d;
    logic [3:0] sh_cnt_q;
    logic [3:0] sh_cnt_d;
    logic [7:0] di_sr_q;
    logic [7:0] ad_sr_q;
    logic [7:0] di_next;
    logic [7:0] ad_next;
    logic shift_en;
    logic word_done;
    logic id_match;
    logic accept;
    // Staged words waiting for the next transmit sync
    logic pend_q;
    logic [7:0] di_stage_q;
    logic [7:0] ad_stage_q;
    logic [1:0] stage_mode;
    // Working settings
    logic [5:0] tx_slot_q;
    logic [5:0] rx_slot_q;
    logic tx_en_q;
    logic rx_en_q;
    logic [2:0] stat_q;
    logic apply;
    logic load_tx;
    logic load_rx;
    logic [5:0] tx_slot_use;
    logic [5:0] rx_slot_use;
    logic tx_en_use;
    logic rx_en_use;
    // Per-direction timing
    logic [1:0] dir_fs;
    logic [1:0] dir_start;
    logic [1:0] dir_en;
    logic [1:0] dir_out;
    logic [5:0] dir_slot [2];
    logic tx_start;
    // Acknowledge timing
    logic ack_arm_q;
    logic [1:0] ack_cnt_q;
    logic ack_hit;

    // every pin level crosses two flops
    // accept built only from synced levels
    assign pins_raw = {hardwired_id_pins, status2_clear, rx_frame_sync,
                       tx_frame_sync, bit_clock_a, addr_ctl_in,
                       slot_mode_serial_in, chip_sel, port_clk};
    tsa_sync #(
        .W(13)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(pins_raw),
        .q(pins_s)
    );
    // Unpack the synchronised bundle
    assign pclk_s = pins_s[0];
    assign cs_s = pins_s[1];
    assign di_s = pins_s[2];
    assign ad_s = pins_s[3];
    assign bck_s = pins_s[4];
    assign fst_s = pins_s[5];
    assign fsr_s = pins_s[6];
    assign clr_s = pins_s[7];
    assign id_s = pins_s[12:8];

    // Edge history registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pclk_prev_q <= 1'b0;
            bck_prev_q <= 1'b0;
        end else begin
            pclk_prev_q <= pclk_s;
            bck_prev_q <= bck_s;
        end
    end
    assign pclk_fall = pclk_prev_q & ~pclk_s;
    assign bck_rise = bck_s & ~bck_prev_q;

    // Shift decode, first bit ends up in the top position
    assign shift_en = (st_q == tsa_pkg::TSA_SHIFT) & cs_s & pclk_fall;
    assign di_next = {di_sr_q[6:0], di_s};
    // address word on the same edges
    assign ad_next = {ad_sr_q[6:0], ad_s};
    assign word_done = shift_en & (sh_cnt_q == tsa_pkg::SH_FULL - 4'h1);
    // only the matching device goes on
    assign id_match = (ad_next[tsa_pkg::ID_MSB:0] == id_s);
    // bank select needs a match, single select does not
    assign accept = word_done & (ADDRESSED ? id_match : 1'b1);

    // Sequencer next state
    always_comb begin
        st_d = st_q;
        sh_cnt_d = sh_cnt_q;
        case (st_q)
            tsa_pkg::TSA_IDLE: begin
                if (cs_s) begin
                    st_d = tsa_pkg::TSA_SHIFT;
                    sh_cnt_d = 4'h0;
                end
            end
            tsa_pkg::TSA_SHIFT: begin
                if (!cs_s) begin
                    // Aborted access, partial word dropped
                    st_d = tsa_pkg::TSA_IDLE;
                end else if (word_done) begin
                    st_d = tsa_pkg::TSA_DONE;
                end else if (shift_en) begin
                    sh_cnt_d = sh_cnt_q + 4'h1;
                end
            end
            tsa_pkg::TSA_DONE: begin
                // extra clocks ignored until select drops
                if (!cs_s) begin
                    st_d = tsa_pkg::TSA_IDLE;
                end
            end
            default: begin
                st_d = tsa_pkg::TSA_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= tsa_pkg::TSA_IDLE;
            sh_cnt_q <= 4'h0;
        end else begin
            st_q <= st_d;
            sh_cnt_q <= sh_cnt_d;
        end
    end

    // shift registers load on trailing edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            di_sr_q <= tsa_pkg::RST_WORD;
            ad_sr_q <= tsa_pkg::RST_WORD;
        end else if (shift_en) begin
            di_sr_q <= di_next;
            ad_sr_q <= ad_next;
        end
    end

    // Transmit frame start drives all updates
    assign tx_start = dir_start[0];
    assign apply = pend_q & tx_start;
    // mode is the first two bits
    assign stage_mode = di_stage_q[tsa_pkg::MODE_MSB:tsa_pkg::MODE_LSB];
    assign load_tx = apply & ((stage_mode == tsa_pkg::MODE_BOTH) |
                              (stage_mode == tsa_pkg::MODE_TX));
    assign load_rx = apply & ((stage_mode == tsa_pkg::MODE_BOTH) |
                              (stage_mode == tsa_pkg::MODE_RX));

    // staged word waits for next sync, set wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            di_stage_q <= tsa_pkg::RST_WORD;
            ad_stage_q <= tsa_pkg::RST_WORD;
        end else if (accept) begin
            pend_q <= 1'b1;
            di_stage_q <= di_next;
            ad_stage_q <= ad_next;
        end else if (apply) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_slot_q <= tsa_pkg::RST_SLOT;
            rx_slot_q <= tsa_pkg::RST_SLOT;
            tx_en_q <= 1'b0;
            rx_en_q <= 1'b0;
        end else begin
            tx_slot_q <= tx_slot_use;
            rx_slot_q <= rx_slot_use;
            tx_en_q <= tx_en_use;
            rx_en_q <= rx_en_use;
        end
    end
    // slot number in the last six bits
    assign tx_slot_use = load_tx ? di_stage_q[tsa_pkg::SLOT_MSB:0]
                                 : tx_slot_q;
    assign rx_slot_use = load_rx ? di_stage_q[tsa_pkg::SLOT_MSB:0]
                                 : rx_slot_q;
    // idle stops both, rx only leaves tx alone
    assign tx_en_use = load_tx ? 1'b1 :
                       (apply & (stage_mode == tsa_pkg::MODE_IDLE)) ? 1'b0 :
                       tx_en_q;
    assign rx_en_use = load_rx ? 1'b1 :
                       (apply & (stage_mode == tsa_pkg::MODE_IDLE)) ? 1'b0 :
                       rx_en_q;

    // status from first three address bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_q <= tsa_pkg::RST_STATUS;
        end else begin
            if (apply & ADDRESSED) begin
                stat_q <= ad_stage_q[tsa_pkg::STAT_MSB:tsa_pkg::STAT_LSB];
            end
            if (clr_s) begin
                stat_q[tsa_pkg::STAT_Q2] <= 1'b0;
            end
        end
    end
    assign status_out0 = stat_q[tsa_pkg::STAT_Q0];
    assign status_out1 = stat_q[tsa_pkg::STAT_Q1];
    assign status_out2 = stat_q[tsa_pkg::STAT_Q2];

    // Direction inputs, index 0 transmit and 1 receive
    assign dir_fs = {fsr_s, fst_s};
    assign dir_en = {rx_en_use, tx_en_use};
    assign dir_slot[0] = tx_slot_use;
    assign dir_slot[1] = rx_slot_use;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_dir
            tsa_slot_timer u_timer (
                .clk(clk),
                .resetn(resetn),
                .bck_rise(bck_rise),
                .fs(dir_fs[g]),
                .slot(dir_slot[g]),
                .en(dir_en[g]),
                .frame_start(dir_start[g]),
                .enable_q(dir_out[g])
            );
        end
    endgenerate
    assign tx_slot_enable = dir_out[0];
    assign rx_slot_enable = dir_out[1];

    // third bit clock after the sync
    assign ack_hit = ack_arm_q & bck_rise & ~tx_start &
                     (ack_cnt_q == tsa_pkg::ACK_DELAY - 2'h1);

    // pull at delay, release at next sync
    // armed only by this device's accept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_arm_q <= 1'b0;
            ack_cnt_q <= 2'h0;
            ack_oe <= 1'b0;
        end else if (tx_start) begin
            ack_arm_q <= apply;
            ack_cnt_q <= 2'h0;
            ack_oe <= 1'b0;
        end else if (ack_hit) begin
            ack_arm_q <= 1'b0;
            ack_oe <= 1'b1;
        end else if (ack_arm_q & bck_rise) begin
            ack_cnt_q <= ack_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_out <= 1'b0;
        end else begin
            ack_out <= 1'b0;
        end
    end

    property p_ack_low;
        @(posedge clk) disable iff (!resetn)
        ack_oe |-> !ack_out;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("acknowledge driven high");

    property p_clr;
        @(posedge clk) disable iff (!resetn)
        clr_s |=> !status_out2;
    endproperty
    a_clr: assert property (p_clr)
        else $error("third status not cleared");

    // mismatching word leaves the staged word alone
    property p_match;
        @(posedge clk) disable iff (!resetn)
        (word_done & ADDRESSED &
         (ad_next[tsa_pkg::ID_MSB:0] != id_s)) |=>
            ($stable(di_stage_q) && $stable(ad_stage_q) && !$rose(pend_q));
    endproperty
    a_match: assert property (p_match)
        else $error("accepted without identity match");

    // word completes on the eighth edge
    property p_eight;
        @(posedge clk) disable iff (!resetn)
        word_done |-> (sh_cnt_q == 4'h7) && pclk_fall;
    endproperty
    a_eight: assert property (p_eight)
        else $error("word not eight bits");

    // shift only on a port clock fall
    property p_fall;
        @(posedge clk) disable iff (!resetn)
        (di_sr_q != $past(di_sr_q)) |-> $past(pclk_fall);
    endproperty
    a_fall: assert property (p_fall)
        else $error("shift without trailing edge");

    // pull starts only on a bit clock rise
    property p_ack_rise;
        @(posedge clk) disable iff (!resetn)
        $rose(ack_oe) |-> $past(bck_rise) && $past(ack_cnt_q) == 2'h2;
    endproperty
    a_ack_rise: assert property (p_ack_rise)
        else $error("acknowledge at wrong bit clock");

    property p_ack_rel;
        @(posedge clk) disable iff (!resetn)
        (tx_start & ack_oe) |=> !ack_oe;
    endproperty
    a_ack_rel: assert property (p_ack_rel)
        else $error("acknowledge not released");

    // transmit slot changes only at a transmit sync
    property p_apply;
        @(posedge clk) disable iff (!resetn)
        $changed(tx_slot_q) |-> $past(apply);
    endproperty
    a_apply: assert property (p_apply)
        else $error("slot changed mid frame");

    property p_stat;
        @(posedge clk) disable iff (!resetn)
        (apply & ADDRESSED & !clr_s) |=>
            (status_out0 == $past(ad_stage_q[5]));
    endproperty
    a_stat: assert property (p_stat)
        else $error("status not loaded");
endmodule // tsa_top

// *** verification/tsa_host_model.sv ***
// Host processor model driving the serial programming port
`timescale 1ns/100ps
module tsa_host_model #(
    parameter int LEVEL_CLKS = 6
) (
    input wire logic clk,
    input wire logic ack_wire,
    output logic port_clk,
    output logic chip_sel,
    output logic slot_mode_serial_in,
    output logic addr_ctl_in
);
    initial begin
        port_clk = 1'b0;
        chip_sel = 1'b0;
        slot_mode_serial_in = 1'b0;
        addr_ctl_in = 1'b1;
    end

    // Let n edges pass, then step off the edge
    task automatic hold_clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Shift n bits of both words, bit 7 first
    task automatic send(input logic [7:0] di_w, input logic [7:0] ad_w,
                        input int n);
        hold_clks(LEVEL_CLKS);
        chip_sel = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            // true bit only around the fall
            slot_mode_serial_in = ~di_w[i];
            addr_ctl_in = ~ad_w[i];
            hold_clks(LEVEL_CLKS);
            port_clk = 1'b1;
            hold_clks(2);
            slot_mode_serial_in = di_w[i];
            addr_ctl_in = ad_w[i];
            hold_clks(LEVEL_CLKS);
            port_clk = 1'b0;
            hold_clks(LEVEL_CLKS);
        end
        // Short word: select dropped early
        if (n < 8) drop();
    endtask

    // hold select until acknowledge or bound
    task automatic await_ack(input int bound, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < bound && !seen; i++) begin
            // Look off the edge, once the design output has settled
            hold_clks(1);
            seen = (ack_wire === 1'b0);
        end
        hold_clks(1);
        drop();
    endtask

    // Release select; data lines lose their value
    task automatic drop();
        chip_sel = 1'b0;
        slot_mode_serial_in = ~slot_mode_serial_in;
        addr_ctl_in = ~addr_ctl_in;
    endtask
endmodule // tsa_host_model

// *** verification/testbench.sv ***
// Self-checking bench for the time slot assigner
`timescale 1ns/100ps
module testbench;
    // Ten slots a frame, rx lags tx by two bits
    localparam int FRAME_BITS = 80;
    localparam int RX_OFFSET = 2;
    // System clocks per bit clock
    localparam int BIT_CLKS = 8;
    localparam logic [5:0] CORNER_SLOT [4] = '{6'h00, 6'h08, 6'h03, 6'h05};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic port_clk, chip_sel, slot_mode_serial_in, addr_ctl_in;
    logic [4:0] hardwired_id_pins = 5'h00;
    logic bit_clock_a = 1'b0;
    logic tx_frame_sync = 1'b0;
    logic rx_frame_sync = 1'b0;
    logic status2_clear = 1'b0;
    logic status_out0, status_out1, status_out2;
    logic tx_slot_enable, rx_slot_enable, ack_out, ack_oe;
    // Shared acknowledge line with weak pull-up
    wire logic ack_wire = ack_oe ? ack_out : 1'b1;
    wire logic [2:0] stat_seen = {status_out2, status_out1, status_out0};
    int err_total = 0;
    int samples_checked = 0;
    // Bit clock phase and bit counts
    int ph = BIT_CLKS - 1;
    int gbit = 0;
    int tbit, rbit;
    // Expected settings and staged word
    logic tx_on = 1'b0;
    logic rx_on = 1'b0;
    logic [5:0] tx_slot = 6'h00;
    logic [5:0] rx_slot = 6'h00;
    logic [2:0] stat = 3'h0;
    logic ack_frame = 1'b0;
    logic pend = 1'b0;
    logic [7:0] pend_di, pend_ad;
    logic clear_req = 1'b0;
    event frame_ev;

    tsa_top #(.ADDRESSED(1'b1)) tsa_top_inst (
        .clk(clk), .resetn(resetn), .port_clk(port_clk),
        .chip_sel(chip_sel), .slot_mode_serial_in(slot_mode_serial_in),
        .addr_ctl_in(addr_ctl_in), .hardwired_id_pins(hardwired_id_pins),
        .bit_clock_a(bit_clock_a), .tx_frame_sync(tx_frame_sync),
        .rx_frame_sync(rx_frame_sync), .status2_clear(status2_clear),
        .status_out0(status_out0), .status_out1(status_out1),
        .status_out2(status_out2), .tx_slot_enable(tx_slot_enable),
        .rx_slot_enable(rx_slot_enable), .ack_out(ack_out), .ack_oe(ack_oe)
    );
    tsa_host_model #(.LEVEL_CLKS(6)) tsa_host_model_inst (
        .clk(clk), .ack_wire(ack_wire), .port_clk(port_clk),
        .chip_sel(chip_sel), .slot_mode_serial_in(slot_mode_serial_in),
        .addr_ctl_in(addr_ctl_in)
    );

    always #5 clk = ~clk;

    // Compare and count
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Enable expected while the bit lies in the slot
    function automatic logic exp_en(input logic on, input logic [5:0] slot,
                                    input int b);
        return on && (b / tsa_pkg::BITS_PER_SLOT == int'(slot));
    endfunction

    // staged word applied at tx frame start
    task automatic apply();
        logic [1:0] m;
        logic ld_tx, ld_rx;
        m = pend_di[7:6];
        ld_tx = pend && (m == tsa_pkg::MODE_BOTH || m == tsa_pkg::MODE_TX);
        ld_rx = pend && (m == tsa_pkg::MODE_BOTH || m == tsa_pkg::MODE_RX);
        if (ld_tx) tx_slot = pend_di[5:0];
        if (ld_rx) rx_slot = pend_di[5:0];
        if (pend) stat = pend_ad[7:5];
        tx_on = ld_tx || (tx_on && !(pend && m == tsa_pkg::MODE_IDLE));
        rx_on = ld_rx || (rx_on && !(pend && m == tsa_pkg::MODE_IDLE));
        ack_frame = pend;
        pend = 1'b0;
    endtask

    // Bit clock, frame syncs and checks once per bit
    always @(posedge clk) begin
        #1;
        if (ph == BIT_CLKS - 1 && gbit > 4) begin
            chk("tx", tx_slot_enable, exp_en(tx_on, tx_slot, tbit));
            chk("rx", rx_slot_enable, exp_en(rx_on, rx_slot, rbit));
            chk("stat", stat_seen, stat);
            chk("ack", ack_wire, !(ack_frame && tbit >= 3));
        end
        ph = (ph + 1) % BIT_CLKS;
        bit_clock_a = (ph < BIT_CLKS / 2);
        if (ph == 0) begin
            gbit++;
            tbit = gbit % FRAME_BITS;
            rbit = (gbit + FRAME_BITS - RX_OFFSET) % FRAME_BITS;
            status2_clear = clear_req;
            if (tbit == 0) begin
                apply();
                -> frame_ev;
            end
            if (status2_clear) stat[2] = 1'b0;
        end
        // sync high at the slot zero rise
        if (ph == BIT_CLKS / 2) begin
            tx_frame_sync = ((gbit + 1) % FRAME_BITS == 0);
            rx_frame_sync = ((gbit + 1) % FRAME_BITS == RX_OFFSET);
        end
    end

    // One host access; staged only when whole and addressed here
    task automatic xfer(input logic [7:0] di_w, input logic [7:0] ad_w,
                        input int n, input bit sync, input bit get_ack);
        logic seen;
        logic acc;
        if (sync) @(frame_ev);
        tsa_host_model_inst.send(di_w, ad_w, n);
        acc = (n == 8) && (ad_w[4:0] == hardwired_id_pins);
        if (acc) begin
            pend_di = di_w;
            pend_ad = ad_w;
            pend = 1'b1;
        end
        if (n == 8 && get_ack) begin
            tsa_host_model_inst.await_ack(1500, seen);
            chk("ack_seen", seen, acc);
            if (acc && !seen) end_of_test();
        end else if (n == 8) begin
            tsa_host_model_inst.drop();
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] di_w, ad_w;
        int n;
        void'($urandom(90645));
        hardwired_id_pins = 5'($urandom);
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        // Each mode code with slots 0, 8, 3 and 5
        for (int m = 0; m < 4; m++) begin
            di_w = {2'(m), CORNER_SLOT[m]};
            ad_w = {3'(7 - m), hardwired_id_pins};
            xfer(di_w, ad_w, 8, 1, 1);
        end
        // Identity off by one bit, then a short word
        xfer(8'h02, {3'h7, hardwired_id_pins ^ 5'h01}, 8, 1, 1);
        xfer(8'h02, {3'h7, hardwired_id_pins ^ 5'h10}, 8, 1, 1);
        xfer(8'h02, {3'h7, hardwired_id_pins}, 7, 1, 1);
        // Second word in one frame replaces the first
        xfer(8'h45, {3'h2, hardwired_id_pins}, 8, 1, 0);
        xfer(8'h87, {3'h5, hardwired_id_pins}, 8, 0, 1);
        // Load arriving while clear is held
        clear_req = 1'b1;
        xfer(8'h01, {3'h7, hardwired_id_pins}, 8, 1, 1);
        clear_req = 1'b0;
        // Random accesses
        for (int i = 0; i < 20; i++) begin
            di_w = {2'($urandom_range(3)), 6'($urandom_range(8))};
            ad_w = {3'($urandom), hardwired_id_pins};
            if ($urandom_range(3) == 0) ad_w[4:0] ^= 5'($urandom_range(31, 1));
            n = ($urandom_range(5) == 0) ? $urandom_range(7, 1) : 8;
            clear_req = ($urandom_range(4) == 0);
            xfer(di_w, ad_w, n, 1, 1);
        end
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule // testbench
